/* File: verilog/hsp_defines.svh */
// Constant definitions shared by the host slave port design files.
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH

// Width of the host data bus and of each data latch.
`define HSP_DATA_W 8
// Direction pattern that marks all three strobe pins as inputs.
`define HSP_DIR_ALL_IN 3'h7
// Reset value of both data latches and of the pin output register.
`define HSP_BYTE_RST 8'h00
// Idle level of an active-low strobe after reset.
`define HSP_STROBE_IDLE 1'h1
// Number of flip-flops in each pin synchroniser chain.
`define HSP_SYNC_STAGES 2

`endif

/* File: verilog/hsp_pkg.sv */
// Types shared by the host slave port design files.
`include "hsp_defines.svh"

package hsp_pkg;

   // One byte on the host data bus.
   typedef logic [`HSP_DATA_W-1:0] hsp_byte_t;

endpackage

/* File: verilog/hsp_pins_if.sv */
// Interface carrying the synchronised host pins from the synchroniser to the core.
`timescale 1ns/1ns

interface hsp_pins_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   hsp_pkg::hsp_byte_t data;

   // The synchroniser drives the pins, the core only reads them.
   modport sync (output cs_n, output rd_n, output wr_n, output data);
   modport core (input cs_n, input rd_n, input wr_n, input data);
endinterface

/* File: verilog/hsp_sync.sv */
// Two-stage synchroniser for the host strobes and data bus.
`timescale 1ns/1ns
`include "hsp_defines.svh"

module hsp_sync (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire hsp_pkg::hsp_byte_t i_data,
   hsp_pins_if.sync pins
);

   logic [2:0] strb_meta_q;
   logic [2:0] strb_sync_q;
   hsp_pkg::hsp_byte_t data_meta_q;
   hsp_pkg::hsp_byte_t data_sync_q;

   // Strobes idle high, so a reset never fakes the start of a transfer.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         strb_meta_q <= {3{`HSP_STROBE_IDLE}};
         strb_sync_q <= {3{`HSP_STROBE_IDLE}};
      end else if (i_ce) begin
         strb_meta_q <= {i_cs_n, i_rd_n, i_wr_n};
         strb_sync_q <= strb_meta_q;
      end
   end

   // The data bus is sampled with the same latency as the strobes.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         data_meta_q <= `HSP_BYTE_RST;
         data_sync_q <= `HSP_BYTE_RST;
      end else if (i_ce) begin
         data_meta_q <= i_data;
         data_sync_q <= data_meta_q;
      end
   end

   // Only the second stage leaves this module.
   assign pins.cs_n = strb_sync_q[2];
   assign pins.rd_n = strb_sync_q[1];
   assign pins.wr_n = strb_sync_q[0];
   assign pins.data = data_sync_q;

   // Synchronised strobes follow the pin two enabled edges later.
   property p_sync_delay;
      @(posedge i_clk) disable iff (!i_rstn)
         (i_rstn && i_ce) ##1 (i_rstn && i_ce) |=> (pins.wr_n == $past(i_wr_n, 2));
   endproperty
   a_sync_two_stage: assert property (p_sync_delay)
      else $error("Write strobe did not pass through exactly two stages.");

endmodule

/* File: verilog/hsp_top.sv */
// Host slave port: eight-bit asynchronous microprocessor port onto the data latch.
//
// How it works
// - With the port enabled an external host reads and writes the data latch.
// - Enabled port turns three pins into read, write and active-low select strobes.
// - Write starts on select and write low, byte captured when either rises.
// - End of each host write sets input-full and interrupt flags.
// - Select and read low drive the latch onto pins and set output-full.
// - Software write during a host read shows at once, output-full untouched.
// - Select or read high ends the read, releases pins, sets interrupt flag.
// - The port works only in microcontroller mode, not external bus mode.
`timescale 1ns/1ns
`include "hsp_defines.svh"

module hsp_top (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_slave_port_enable,
   input wire logic i_micro_mode,
   input wire logic [2:0] i_strobe_pin_direction,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire hsp_pkg::hsp_byte_t i_data,
   output logic [`HSP_DATA_W-1:0] o_data,
   output logic o_data_oe,
   input wire logic i_sw_wr,
   input wire hsp_pkg::hsp_byte_t i_sw_wdata,
   input wire logic i_sw_rd,
   input wire logic i_obf_clr,
   input wire logic i_irq_clr,
   output logic [`HSP_DATA_W-1:0] o_sw_rdata,
   output logic o_input_buffer_full,
   output logic o_output_buffer_full,
   output logic o_slave_port_irq_flag
);

   hsp_pins_if pins ();

   hsp_pkg::hsp_byte_t in_latch_q;
   hsp_pkg::hsp_byte_t out_latch_q;
   hsp_pkg::hsp_byte_t pin_out_q;
   logic pin_oe_q;
   logic ibf_q;
   logic obf_q;
   logic irq_q;
   logic wr_act_q;
   logic rd_act_q;
   logic port_en;
   logic wr_act;
   logic rd_act;
   logic wr_end;
   logic rd_start;
   logic rd_end;

   // Pins come from outside the clock domain, so they pass the synchroniser first.
   hsp_sync u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_cs_n(i_cs_n),
      .i_rd_n(i_rd_n),
      .i_wr_n(i_wr_n),
      .i_data(i_data),
      .pins(pins)
   );

   // The port exists only in microcontroller mode with all strobe pins set as inputs.
   // A wrong direction setting would let the pin driver fight the host, so it disables the port.
   assign port_en = i_slave_port_enable
                    && i_micro_mode
                    && (i_strobe_pin_direction == `HSP_DIR_ALL_IN);

   // Transfer levels decoded from the synchronised strobes.
   assign wr_act = port_en && !pins.cs_n && !pins.wr_n;
   assign rd_act = port_en && !pins.cs_n && !pins.rd_n;

   // Edges of the transfer levels; disabling the port mid-transfer also ends it.
   assign wr_end = wr_act_q && !wr_act;
   assign rd_start = rd_act && !rd_act_q;
   assign rd_end = rd_act_q && !rd_act;

   // Registered transfer levels for edge detection.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
      end else if (i_ce) begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
      end
   end

   // Host byte is captured only when the write ends, so software never sees a half-written byte.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         in_latch_q <= `HSP_BYTE_RST;
      end else if (i_ce && wr_end) begin
         in_latch_q <= pins.data;
      end
   end

   // Byte that software offers to the host.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         out_latch_q <= `HSP_BYTE_RST;
      end else if (i_ce && i_sw_wr) begin
         out_latch_q <= i_sw_wdata;
      end
   end

   // Pin driver; a software write bypasses the latch so a read in progress sees it at once.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         pin_out_q <= `HSP_BYTE_RST;
         pin_oe_q <= 1'b0;
      end else if (i_ce) begin
         pin_out_q <= i_sw_wr ? i_sw_wdata : out_latch_q;
         pin_oe_q <= rd_act;
      end
   end

   // Input-full flag; a host write ending in the same cycle as a software read wins.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ibf_q <= 1'b0;
      end else if (i_ce) begin
         if (wr_end) begin
            ibf_q <= 1'b1;
         end else if (i_sw_rd) begin
            ibf_q <= 1'b0;
         end
      end
   end

   // Output-full flag is set only by the start of a host read, never by software writes.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         obf_q <= 1'b0;
      end else if (i_ce) begin
         if (rd_start) begin
            obf_q <= 1'b1;
         end else if (i_obf_clr) begin
            obf_q <= 1'b0;
         end
      end
   end

   // Interrupt flag marks the end of either transfer; set wins over a software clear.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         irq_q <= 1'b0;
      end else if (i_ce) begin
         if (wr_end || rd_end) begin
            irq_q <= 1'b1;
         end else if (i_irq_clr) begin
            irq_q <= 1'b0;
         end
      end
   end

   // Every output comes straight from a flip-flop.
   assign o_data = pin_out_q;
   assign o_data_oe = pin_oe_q;
   assign o_sw_rdata = in_latch_q;
   assign o_input_buffer_full = ibf_q;
   assign o_output_buffer_full = obf_q;
   assign o_slave_port_irq_flag = irq_q;

   // Checks on the flags, latch and pin driver.
   a_wr_sets_flags: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && wr_end) |=> (o_input_buffer_full && o_slave_port_irq_flag))
      else $error("Host write end did not set input-full and interrupt flags.");

   a_wr_captures_byte: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && wr_end) |=> (o_sw_rdata == $past(pins.data)))
      else $error("Host byte not captured at the end of the write.");

   a_latch_holds: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         !(i_ce && wr_end) |=> $stable(o_sw_rdata))
      else $error("Host byte changed without a completed host write.");

   a_sw_read_clears: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && i_sw_rd && !wr_end) |=> !o_input_buffer_full)
      else $error("Software read did not clear input-full.");

   a_rd_drives_pins: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && rd_start) |=> (o_data_oe && o_output_buffer_full))
      else $error("Host read start did not drive pins and set output-full.");

   a_rd_end_release: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && rd_end) |=> (!o_data_oe && o_slave_port_irq_flag))
      else $error("Host read end did not release pins and set interrupt flag.");

   a_sw_wr_in_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && i_sw_wr && rd_act) |=> (o_data == $past(i_sw_wdata) && o_data_oe))
      else $error("Software write during host read was not driven at once.");

   a_obf_only_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (!o_output_buffer_full && !(i_ce && rd_start)) |=> !o_output_buffer_full)
      else $error("Output-full set without a host read start.");

   a_disabled_quiet: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
         (i_ce && !port_en) ##1 (i_ce && !port_en) |=> !o_data_oe)
      else $error("Pins driven while the port is disabled.");

   // Main scenarios.
   c_host_write: cover property (@(posedge i_clk) disable iff (!i_rstn) i_ce && wr_end);
   c_host_read: cover property (@(posedge i_clk) disable iff (!i_rstn) rd_start ##[1:20] rd_end);
   c_sw_wr_in_read: cover property (@(posedge i_clk) disable iff (!i_rstn) i_ce && i_sw_wr && rd_act);

endmodule

/* File: sim/hsp_host_model.sv */
// Behavioural external microprocessor driving the host strobes and data bus.
`timescale 1ns/1ns
module hsp_host_model (
   input wire logic i_clk,
   input wire hsp_pkg::hsp_byte_t i_data,
   input wire logic i_data_oe,
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_wr_n,
   output hsp_pkg::hsp_byte_t o_data
);
   // Strobes idle high and the bus carries a pattern of no meaning.
   initial begin
      o_cs_n = 1'h1;
      o_rd_n = 1'h1;
      o_wr_n = 1'h1;
      o_data = 8'h5A;
   end

   // Write strobes low for hold cycles; the byte outlives the strobes by three cycles, more than the sync delay.
   task automatic write_byte(input hsp_pkg::hsp_byte_t b, input int hold);
      @(posedge i_clk);
      o_data <= b;
      o_cs_n <= 1'h0;
      o_wr_n <= 1'h0;
      repeat (hold) @(posedge i_clk);
      o_wr_n <= 1'h1;
      o_cs_n <= 1'h1;
      repeat (3) @(posedge i_clk);
      o_data <= ~b; // A released bus must not keep showing the old byte.
   endtask

   // Read strobes low, then wait a bounded time for the device to drive the pins.
   task automatic read_start(output hsp_pkg::hsp_byte_t b);
      int n;
      n = 0;
      @(posedge i_clk);
      o_data <= ~o_data;
      o_cs_n <= 1'h0;
      o_rd_n <= 1'h0;
      @(posedge i_clk);
      #1;
      while (i_data_oe !== 1'h1 && n < 8) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      b = i_data;
   endtask

   // Raising the strobes ends the read.
   task automatic read_end;
      @(posedge i_clk);
      o_rd_n <= 1'h1;
      o_cs_n <= 1'h1;
   endtask
endmodule

/* File: sim/tb_hsp_top.sv */
// Self-checking testbench for the host slave port.
`timescale 1ns/1ns
module tb_hsp_top;
   logic clk, rstn, ce, en, micro, sw_wr, sw_rd, obf_clr, irq_clr, cs_n, rd_n, wr_n, oe, input_buffer_full, output_buffer_full, irq;
   logic [2:0] dir;
   hsp_pkg::hsp_byte_t hdata, odata, sw_wdata, rdata, b, got, last_wr;
   int err_count, num_checks, i;
   int unsigned seed;

   hsp_top dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_slave_port_enable(en), .i_micro_mode(micro),
      .i_strobe_pin_direction(dir), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(hdata),
      .o_data(odata), .o_data_oe(oe), .i_sw_wr(sw_wr), .i_sw_wdata(sw_wdata), .i_sw_rd(sw_rd),
      .i_obf_clr(obf_clr), .i_irq_clr(irq_clr), .o_sw_rdata(rdata), .o_input_buffer_full(input_buffer_full),
      .o_output_buffer_full(output_buffer_full), .o_slave_port_irq_flag(irq));
   hsp_host_model host (.i_clk(clk), .i_data(odata), .i_data_oe(oe), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_data(hdata));

   // Free-running core clock, 8 ns period.
   always #4 clk = ~clk;

   // Repeatable pseudo-random source.
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // The port answers only when enabled, in microcontroller mode, with all strobe pins as inputs.
   function automatic logic port_on(input logic e, input logic m, input logic [2:0] d);
      return e & m & (d == 3'h7);
   endfunction

   // Counts every comparison and reports each mismatch, unknowns included.
   task automatic check(input hsp_pkg::hsp_byte_t seen, input hsp_pkg::hsp_byte_t exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle software pulse; outputs are settled on return.
   task automatic sw(input logic w, input logic r, input logic oc, input logic ic, input hsp_pkg::hsp_byte_t d);
      @(posedge clk);
      sw_wr <= w;
      sw_rd <= r;
      obf_clr <= oc;
      irq_clr <= ic;
      sw_wdata <= d;
      @(posedge clk);
      {sw_wr, sw_rd, obf_clr, irq_clr} <= 4'h0;
      #1;
   endtask

   // Single place where the run ends and the verdict is printed.
   task automatic end_sim;
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // A hang is cut short well beyond the expected run length.
   initial begin
      #200000;
      err_count++;
      end_sim();
   end

   initial begin
      {clk, rstn, sw_wr, sw_rd, obf_clr, irq_clr} = 6'h00;
      {ce, en, micro} = 3'h7;
      dir = 3'h7;
      sw_wdata = 8'h00;
      seed = 36138;
      err_count = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      #1;
      check({4'h0, oe, input_buffer_full, output_buffer_full, irq}, 8'h00);
      check(rdata, 8'h00);
      // Host writes with boundary bytes and the shortest legal strobe first.
      for (i = 0; i < 8; i++) begin
         b = 8'(xs());
         b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : b;
         host.write_byte(b, 3 + i % 4);
         repeat (4) @(posedge clk);
         #1;
         check(rdata, b);
         check({6'h00, input_buffer_full, irq}, 8'h03);
         sw(1'h0, 1'h1, 1'h0, 1'h1, 8'h00);
         check({6'h00, input_buffer_full, irq}, 8'h00);
         check(rdata, b);
         last_wr = b;
      end
      // Host read, then a software write in mid-read after output-full was cleared.
      got = 8'(xs());
      sw(1'h1, 1'h0, 1'h1, 1'h0, got);
      host.read_start(b);
      check(b, got);
      check({6'h00, oe, output_buffer_full}, 8'h03);
      sw(1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
      sw(1'h1, 1'h0, 1'h0, 1'h0, ~got);
      check(odata, ~got);
      check({7'h00, output_buffer_full}, 8'h00);
      host.read_end();
      repeat (5) @(posedge clk);
      #1;
      check({6'h00, oe, irq}, 8'h01);
      sw(1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
      // Each way of switching the port off must leave host strobes unanswered.
      for (i = 0; i < 3; i++) begin
         @(posedge clk);
         en <= (i != 0);
         micro <= (i != 1);
         dir <= (i == 2) ? 3'h3 : 3'h7;
         host.write_byte(8'hA5, 4);
         host.read_start(b);
         check({5'h00, oe, input_buffer_full, irq}, {5'h00, {3{port_on(en, micro, dir)}}});
         host.read_end();
         repeat (5) @(posedge clk);
         {en, micro} <= 2'h3;
         dir <= 3'h7;
         #1;
         check(rdata, last_wr);
      end
      // A frozen clock enable hides a whole host write, since the synchroniser never moves.
      @(posedge clk);
      ce <= 1'h0;
      host.write_byte(8'h3C, 4);
      repeat (2) @(posedge clk);
      ce <= 1'h1;
      repeat (5) @(posedge clk);
      #1;
      check({6'h00, input_buffer_full, irq}, 8'h00);
      check(rdata, last_wr);
      end_sim();
   end
endmodule
